/* rtl/tbg_top.sv */
// Module: timer rate generator with AXI4-Lite register access
`timescale 1ns/1ps
module tbg_top
  import tbg_pkg::*;
(
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic [ADDR_W-1:0] AWADDR_I,
  input wire logic [2:0] AWPROT_I,
  input wire logic AWVALID_I,
  output logic AWREADY_O,
  input wire logic [31:0] WDATA_I,
  input wire logic [3:0] WSTRB_I,
  input wire logic WVALID_I,
  output logic WREADY_O,
  output logic [1:0] BRESP_O,
  output logic BVALID_O,
  input wire logic BREADY_I,
  input wire logic [ADDR_W-1:0] ARADDR_I,
  input wire logic [2:0] ARPROT_I,
  input wire logic ARVALID_I,
  output logic ARREADY_O,
  output logic [31:0] RDATA_O,
  output logic [1:0] RRESP_O,
  output logic RVALID_O,
  input wire logic RREADY_I,
  input wire logic EXT_COUNT_PIN_I,
  input wire logic TRIGGER_PIN_I,
  input wire logic TIMER1_OVF_I,
  output logic TX_RATE_TICK_O,
  output logic RX_RATE_TICK_O,
  output logic CLOCK_OUT_O,
  output logic TIMER_INT_O
);

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    tbg_bus_t bus;
    tbg_ctrl_t ctrl;
    tbg_mode_t mode;
    logic six_clock;
    tbg_count_t count;
    tbg_reload_t reload;
    logic [3:0] bit_div;
    logic tx_tick;
    logic rx_tick;
    logic clock_out;
  } tbg_state_t;

  tbg_state_t s;
  tbg_state_t next_s;

  logic ext_fall;
  logic trig_level;
  logic trig_fall;
  logic fast_tick;
  logic machine_tick;

  tbg_sync_edge u_count_pin (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .pin_i(EXT_COUNT_PIN_I),
    .level_o(),
    .fall_o(ext_fall)
  );

  tbg_sync_edge u_trigger_pin (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .pin_i(TRIGGER_PIN_I),
    .level_o(trig_level),
    .fall_o(trig_fall)
  );

  tbg_prescale u_prescale (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .six_clock_i(s.six_clock),
    .fast_tick_o(fast_tick),
    .machine_tick_o(machine_tick)
  );

  // Byte-lane merge for a register write
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] data,
                                          input logic [3:0] strb);
    logic [15:0] res;
    res = old;
    if (strb[0]) begin
      res[7:0] = data[7:0];
    end
    if (strb[1]) begin
      res[15:8] = data[15:8];
    end
    return res;
  endfunction : merge16

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    return (a == ADDR_CTRL) || (a == ADDR_MODE) || (a == ADDR_COUNT) ||
           (a == ADDR_RELOAD) || (a == ADDR_CFG);
  endfunction : mapped

  // ************************************************************
  // Next-state logic
  // ************************************************************
  logic rate_mode;
  logic up_down_active;
  logic inc;
  logic wr_fire;
  logic ovf;
  logic [15:0] wr16;

  always_comb begin
    next_s = s;
    ovf = 1'b0;
    wr16 = 16'h0000;
    rate_mode = s.ctrl.rx_rate_source_select | s.ctrl.tx_rate_source_select;
    up_down_active = s.mode.up_down_count_enable & ~rate_mode &
                     ~s.ctrl.capture_reload_select;
    // Counter source: pin edge, or oscillator-derived tick
    inc = s.ctrl.run_control &
          (s.ctrl.timer_counter_select ? ext_fall :
           (rate_mode ? fast_tick : machine_tick));
    wr_fire = s.bus.aw_full & s.bus.w_full & ~s.bus.bvalid;

    // Bus channel acceptance
    if (AWVALID_I && AWREADY_O) begin
      next_s.bus.aw_full = 1'b1;
      next_s.bus.awaddr = AWADDR_I;
    end
    if (WVALID_I && WREADY_O) begin
      next_s.bus.w_full = 1'b1;
      next_s.bus.wdata = WDATA_I;
      next_s.bus.wstrb = WSTRB_I;
    end
    if (BVALID_O && BREADY_I) begin
      next_s.bus.bvalid = 1'b0;
    end
    if (RVALID_O && RREADY_I) begin
      next_s.bus.rvalid = 1'b0;
    end
    if (ARVALID_I && ARREADY_O) begin
      next_s.bus.rvalid = 1'b1;
      next_s.bus.rresp = mapped(ARADDR_I) ? RESP_OKAY : RESP_SLVERR;
      case (ARADDR_I)
        ADDR_CTRL: next_s.bus.rdata = {24'h000000, s.ctrl};
        ADDR_MODE: next_s.bus.rdata = {24'h000000, 6'h00, s.mode[1:0]};
        ADDR_COUNT: next_s.bus.rdata = {16'h0000, s.count};
        ADDR_RELOAD: next_s.bus.rdata = {16'h0000, s.reload};
        ADDR_CFG: next_s.bus.rdata = {31'h00000000, s.six_clock};
        default: next_s.bus.rdata = 32'h00000000;
      endcase
    end

    // Control writes first so hardware flag sets below win
    if (wr_fire) begin
      next_s.bus.aw_full = 1'b0;
      next_s.bus.w_full = 1'b0;
      next_s.bus.bvalid = 1'b1;
      next_s.bus.bresp = mapped(s.bus.awaddr) ? RESP_OKAY : RESP_SLVERR;
      if (s.bus.wstrb[0]) begin
        case (s.bus.awaddr)
          ADDR_CTRL: next_s.ctrl = s.bus.wdata[7:0];
          ADDR_MODE: next_s.mode = {6'h00, s.bus.wdata[1:0]};
          ADDR_CFG: next_s.six_clock = s.bus.wdata[0];
          default: next_s.six_clock = s.six_clock;
        endcase
      end
    end

    // Counting, overflow and reload
    if (inc) begin
      if (up_down_active && !trig_level) begin
        if (s.count == s.reload) begin
          next_s.count = COUNT_TOP;
          next_s.ctrl.overflow_flag = 1'b1;
          next_s.ctrl.external_trigger_flag = ~s.ctrl.external_trigger_flag;
        end else begin
          next_s.count = s.count - 16'h0001;
        end
      end else if (s.count == COUNT_TOP) begin
        ovf = 1'b1;
        if (s.ctrl.capture_reload_select && !rate_mode) begin
          next_s.count = COUNT_ZERO;
        end else begin
          next_s.count = s.reload;
        end
        if (!rate_mode) begin
          next_s.ctrl.overflow_flag = 1'b1;
        end
        if (up_down_active) begin
          next_s.ctrl.external_trigger_flag = ~s.ctrl.external_trigger_flag;
        end
      end else begin
        next_s.count = s.count + 16'h0001;
      end
    end

    // Trigger edge: flag in every mode but up/down counting, capture or reload only outside rate mode
    if (trig_fall && s.ctrl.external_trigger_enable && !up_down_active) begin
      next_s.ctrl.external_trigger_flag = 1'b1;
      if (!rate_mode) begin
        if (s.ctrl.capture_reload_select) begin
          next_s.reload = s.count;
        end else begin
          next_s.count = s.reload;
        end
      end
    end

    // Count and reload writes override the hardware; software must stop first
    if (wr_fire && (s.bus.awaddr == ADDR_COUNT)) begin
      wr16 = merge16(s.count, s.bus.wdata, s.bus.wstrb);
      next_s.count = wr16;
    end
    if (wr_fire && (s.bus.awaddr == ADDR_RELOAD)) begin
      wr16 = merge16(s.reload, s.bus.wdata, s.bus.wstrb);
      next_s.reload = wr16;
    end

    // Sixteen overflows make one bit period
    if (ovf) begin
      next_s.bit_div = s.bit_div + 4'h1;
    end
    next_s.tx_tick = s.ctrl.tx_rate_source_select ?
                     (ovf && (s.bit_div == BIT_DIV_LAST)) : TIMER1_OVF_I;
    next_s.rx_tick = s.ctrl.rx_rate_source_select ?
                     (ovf && (s.bit_div == BIT_DIV_LAST)) : TIMER1_OVF_I;
    if (ovf && s.mode.timer_output_enable) begin
      next_s.clock_out = ~s.clock_out;
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      s <= '0;
      s.ctrl <= CTRL_RESET;
      s.mode <= MODE_RESET;
    end else begin
      s <= next_s;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign AWREADY_O = ~s.bus.aw_full & ~s.bus.bvalid;
  assign WREADY_O = ~s.bus.w_full & ~s.bus.bvalid;
  assign BVALID_O = s.bus.bvalid;
  assign BRESP_O = s.bus.bresp;
  assign ARREADY_O = ~s.bus.rvalid;
  assign RVALID_O = s.bus.rvalid;
  assign RDATA_O = s.bus.rdata;
  assign RRESP_O = s.bus.rresp;
  assign TX_RATE_TICK_O = s.tx_tick;
  assign RX_RATE_TICK_O = s.rx_tick;
  assign CLOCK_OUT_O = s.clock_out;
  // Interrupt gating lives outside; only the request level is formed here
  assign TIMER_INT_O = s.ctrl.overflow_flag |
                       (s.ctrl.external_trigger_flag & ~s.mode.up_down_count_enable);
endmodule : tbg_top

/* rtl/tbg_pkg.sv */
// Package: register map, field layouts and constants of the timer rate generator
// Contract
// - Transmit-select 1 takes transmit rate from here
// - Receive-select likewise, independent of transmit
// - High-byte rollover reloads count from reload pair
// - Bit rate is overflow rate over 16
// - Rate mode counts every 1 or 2 osc
// - Timer mode counts every 6 or 12 osc
// - Bit rate osc over n times period
// - Rate mode only while a select bit set
// - Rate-mode rollover sets no overflow flag
// - Rate-mode trigger edge sets flag, no reload
// - Rate mode may count external pin edges
// - Timer control set-up values as listed
// - Trigger edge reloads/captures except rate mode
// - Counter control set-up values as listed
// - Up/down enable masks external flag interrupt
package tbg_pkg;
  localparam int ADDR_W = 5;
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 5'h00;
  localparam logic [ADDR_W-1:0] ADDR_MODE = 5'h04;
  localparam logic [ADDR_W-1:0] ADDR_COUNT = 5'h08;
  localparam logic [ADDR_W-1:0] ADDR_RELOAD = 5'h0C;
  localparam logic [ADDR_W-1:0] ADDR_CFG = 5'h10;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [15:0] COUNT_TOP = 16'hFFFF;
  localparam logic [15:0] COUNT_ZERO = 16'h0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Oscillator prescaler: machine cycle is 12 or 6 oscillator periods
  localparam logic [3:0] PRE_LAST_12 = 4'hB;
  localparam logic [3:0] PRE_HALF_6 = 4'h5;
  // Sixteen overflows per bit period
  localparam logic [3:0] BIT_DIV_LAST = 4'hF;

  // ************************************************************
  // Register layouts
  // ************************************************************
  typedef struct packed {
    logic overflow_flag;
    logic external_trigger_flag;
    logic rx_rate_source_select;
    logic tx_rate_source_select;
    logic external_trigger_enable;
    logic run_control;
    logic timer_counter_select;
    logic capture_reload_select;
  } tbg_ctrl_t;

  typedef struct packed {
    logic [5:0] reserved;
    logic timer_output_enable;
    logic up_down_count_enable;
  } tbg_mode_t;

  typedef struct packed {
    logic [7:0] count_high_byte;
    logic [7:0] count_low_byte;
  } tbg_count_t;

  typedef struct packed {
    logic [7:0] reload_high_byte;
    logic [7:0] reload_low_byte;
  } tbg_reload_t;

  typedef struct packed {
    logic aw_full;
    logic [ADDR_W-1:0] awaddr;
    logic w_full;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } tbg_bus_t;
endpackage : tbg_pkg

/* rtl/tbg_sync_edge.sv */
// Module: two-stage pin synchroniser with falling-edge detect
`timescale 1ns/1ps
module tbg_sync_edge
  import tbg_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic pin_i,
  output logic level_o,
  output logic fall_o
);
  typedef struct packed {
    logic meta;
    logic sync;
    logic last;
  } tbg_sync_t;

  tbg_sync_t s;
  tbg_sync_t next_s;

  always_comb begin
    next_s = s;
    next_s.meta = pin_i;
    next_s.sync = s.meta;
    next_s.last = s.sync;
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s <= '{meta: 1'b1, sync: 1'b1, last: 1'b1};
    end else begin
      s <= next_s;
    end
  end

  // Only the second stage and its delayed copy feed logic
  assign level_o = s.sync;
  assign fall_o = s.last & ~s.sync;
endmodule : tbg_sync_edge

/* rtl/tbg_prescale.sv */
// Module: oscillator prescaler giving rate-mode and machine-cycle ticks
`timescale 1ns/1ps
module tbg_prescale
  import tbg_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic six_clock_i,
  output logic fast_tick_o,
  output logic machine_tick_o
);
  typedef struct packed {
    logic [3:0] phase;
  } tbg_pre_t;

  tbg_pre_t s;
  tbg_pre_t next_s;

  always_comb begin
    next_s = s;
    next_s.phase = (s.phase == PRE_LAST_12) ? 4'h0 : s.phase + 4'h1;
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // Every oscillator period in 6-clock mode, every second one otherwise
  assign fast_tick_o = six_clock_i | s.phase[0];
  assign machine_tick_o = (s.phase == PRE_LAST_12) |
                          (six_clock_i & (s.phase == PRE_HALF_6));
endmodule : tbg_prescale

/* dv/tbg_checker.sv */
// Checker: bus handshake and rate tick assertions
`timescale 1ns/1ps
module tbg_checker
  import tbg_pkg::*;
(
  input logic CLK_I,
  input logic RST_I,
  input logic AWVALID_I,
  input logic AWREADY_O,
  input logic WVALID_I,
  input logic WREADY_O,
  input logic [1:0] BRESP_O,
  input logic BVALID_O,
  input logic BREADY_I,
  input logic [ADDR_W-1:0] ARADDR_I,
  input logic ARVALID_I,
  input logic ARREADY_O,
  input logic [31:0] RDATA_O,
  input logic [1:0] RRESP_O,
  input logic RVALID_O,
  input logic RREADY_I,
  input logic TIMER1_OVF_I,
  input logic TX_RATE_TICK_O,
  input logic RX_RATE_TICK_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  a_b_block: assert property (BVALID_O |-> !AWREADY_O && !WREADY_O)
    else $error("write taken with response pending");
  a_r_block: assert property (RVALID_O |-> !ARREADY_O)
    else $error("read taken with data pending");
  // Both channels land in holding registers first; the response follows one cycle later
  a_wr_lat: assert property (AWVALID_I && AWREADY_O && WVALID_I && WREADY_O |-> ##2 BVALID_O)
    else $error("write response late");
  a_rd_lat: assert property (ARVALID_I && ARREADY_O |=> RVALID_O)
    else $error("read data late");
  a_b_hold: assert property (BVALID_O && !BREADY_I |=> BVALID_O && $stable(BRESP_O))
    else $error("write response dropped");
  a_r_hold: assert property (RVALID_O && !RREADY_I |=> RVALID_O && $stable(RDATA_O))
    else $error("read data dropped");
  a_r_drop: assert property (RVALID_O && RREADY_I |=> !RVALID_O)
    else $error("read data repeated");
  a_rd_err: assert property (ARVALID_I && ARREADY_O && ARADDR_I > ADDR_CFG
    |=> RRESP_O == RESP_SLVERR && RDATA_O == 32'h0) else $error("unmapped read");
  // A tick not from timer 1 needs sixteen overflows, so eight quiet cycles is safe
  a_tx_gap: assert property (TX_RATE_TICK_O && !$past(TIMER1_OVF_I) |=>
    (!TX_RATE_TICK_O || $past(TIMER1_OVF_I)) [*8]) else $error("tx ticks too close");
  a_rx_gap: assert property (RX_RATE_TICK_O && !$past(TIMER1_OVF_I) |=>
    (!RX_RATE_TICK_O || $past(TIMER1_OVF_I)) [*8]) else $error("rx ticks too close");
endmodule : tbg_checker
bind tbg_top tbg_checker u_chk (.CLK_I(CLK_I), .RST_I(RST_I), .AWVALID_I(AWVALID_I),
  .AWREADY_O(AWREADY_O), .WVALID_I(WVALID_I), .WREADY_O(WREADY_O), .BRESP_O(BRESP_O),
  .BVALID_O(BVALID_O), .BREADY_I(BREADY_I), .ARADDR_I(ARADDR_I), .ARVALID_I(ARVALID_I),
  .ARREADY_O(ARREADY_O), .RDATA_O(RDATA_O), .RRESP_O(RRESP_O), .RVALID_O(RVALID_O),
  .RREADY_I(RREADY_I), .TIMER1_OVF_I(TIMER1_OVF_I), .TX_RATE_TICK_O(TX_RATE_TICK_O),
  .RX_RATE_TICK_O(RX_RATE_TICK_O));

/* dv/tbg_serial_model.sv */
// Partner: serial rate side, gives timer 1 overflows and counts rate ticks
`timescale 1ns/1ps
module tbg_serial_model
  import tbg_pkg::*;
(
  input logic clk_i,
  input logic rst_i,
  input logic tx_tick_i,
  input logic rx_tick_i,
  input logic clear_i,
  output logic timer1_ovf_o,
  output logic [7:0] tx_count_o,
  output logic [7:0] rx_count_o
);
  logic [2:0] div;
  // Period of five, so any 160-cycle window holds exactly 32 pulses
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      div <= 3'h0;
      timer1_ovf_o <= 1'b0;
      tx_count_o <= 8'h00;
      rx_count_o <= 8'h00;
    end else begin
      div <= (div == 3'h4) ? 3'h0 : div + 3'h1;
      timer1_ovf_o <= (div == 3'h4);
      tx_count_o <= clear_i ? 8'h00 : tx_count_o + {7'h00, tx_tick_i};
      rx_count_o <= clear_i ? 8'h00 : rx_count_o + {7'h00, rx_tick_i};
    end
  end
endmodule : tbg_serial_model

/* dv/test_timer2_baud_rate_generator.sv */
// Testbench: registers, rate sources, trigger flag and pin counting
`timescale 1ns/1ps
module test_timer2_baud_rate_generator
  import tbg_pkg::*;
;
  logic CLK_I, RST_I, AWVALID_I, WVALID_I, BREADY_I, ARVALID_I, RREADY_I;
  logic AWREADY_O, WREADY_O, BVALID_O, ARREADY_O, RVALID_O, TIMER_INT_O;
  logic EXT_COUNT_PIN_I, TRIGGER_PIN_I, t1_ovf, tx_tick, rx_tick, clear;
  logic [ADDR_W-1:0] AWADDR_I, ARADDR_I;
  logic [31:0] WDATA_I, RDATA_O, d;
  logic [1:0] BRESP_O, RRESP_O, r;
  logic [7:0] tx_cnt, rx_cnt;
  int mismatches = 0;
  int num_checks = 0;
  typedef struct packed {
    logic [7:0] ctrl;
    logic cfg;
    logic [15:0] rl;
    logic [7:0] tx;
    logic [7:0] rx;
  } tbg_row_t;
  // Timer 1 gives 32 ticks per window; timer 2 gives 160 / (16 * n * (65536 - reload))
  tbg_row_t rows [6] = '{'{8'h34, 1'b1, 16'hFFFF, 8'h0A, 8'h0A},
    '{8'h24, 1'b1, 16'hFFFF, 8'h20, 8'h0A}, '{8'h14, 1'b0, 16'hFFFF, 8'h05, 8'h20},
    '{8'h04, 1'b1, 16'hFFFF, 8'h20, 8'h20}, '{8'h34, 1'b1, 16'hFFFE, 8'h05, 8'h05},
    '{8'h34, 1'b0, 16'hFFFB, 8'h01, 8'h01}};
  tbg_top dut (.CLK_I(CLK_I), .RST_I(RST_I), .AWADDR_I(AWADDR_I), .AWPROT_I(3'h0),
    .AWVALID_I(AWVALID_I), .AWREADY_O(AWREADY_O), .WDATA_I(WDATA_I), .WSTRB_I(4'hF),
    .WVALID_I(WVALID_I), .WREADY_O(WREADY_O), .BRESP_O(BRESP_O), .BVALID_O(BVALID_O),
    .BREADY_I(BREADY_I), .ARADDR_I(ARADDR_I), .ARPROT_I(3'h0), .ARVALID_I(ARVALID_I),
    .ARREADY_O(ARREADY_O), .RDATA_O(RDATA_O), .RRESP_O(RRESP_O), .RVALID_O(RVALID_O),
    .RREADY_I(RREADY_I), .EXT_COUNT_PIN_I(EXT_COUNT_PIN_I), .TRIGGER_PIN_I(TRIGGER_PIN_I),
    .TIMER1_OVF_I(t1_ovf), .TX_RATE_TICK_O(tx_tick), .RX_RATE_TICK_O(rx_tick),
    .CLOCK_OUT_O(), .TIMER_INT_O(TIMER_INT_O));
  tbg_serial_model u_ser (.clk_i(CLK_I), .rst_i(RST_I), .tx_tick_i(tx_tick),
    .rx_tick_i(rx_tick), .clear_i(clear), .timer1_ovf_o(t1_ovf), .tx_count_o(tx_cnt),
    .rx_count_o(rx_cnt));
  initial begin
    CLK_I = 1'b0;
    forever #5 CLK_I = ~CLK_I;
  end
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : print_verdict
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s exp %0h got %0h", nm, e, g);
    end
  endtask : chk
  task automatic wr(input logic [4:0] a, input logic [31:0] v);
    logic ta, tw;
    @(posedge CLK_I);
    AWADDR_I <= a;
    WDATA_I <= v;
    AWVALID_I <= 1'b1;
    WVALID_I <= 1'b1;
    BREADY_I <= 1'b1;
    ta = 1'b0;
    tw = 1'b0;
    while (!(ta && tw)) begin
      @(negedge CLK_I);
      ta = ta || AWREADY_O;
      tw = tw || WREADY_O;
      @(posedge CLK_I);
      if (ta) AWVALID_I <= 1'b0;
      if (tw) WVALID_I <= 1'b0;
    end
    ta = 1'b0;
    while (!ta) begin
      @(negedge CLK_I);
      ta = BVALID_O;
      r = BRESP_O;
      @(posedge CLK_I);
    end
    BREADY_I <= 1'b0;
  endtask : wr
  task automatic rd(input logic [4:0] a);
    logic t;
    @(posedge CLK_I);
    ARADDR_I <= a;
    ARVALID_I <= 1'b1;
    RREADY_I <= 1'b1;
    t = 1'b0;
    while (!t) begin
      @(negedge CLK_I);
      t = ARREADY_O;
      @(posedge CLK_I);
    end
    ARVALID_I <= 1'b0;
    t = 1'b0;
    while (!t) begin
      @(negedge CLK_I);
      t = RVALID_O;
      d = RDATA_O;
      r = RRESP_O;
      @(posedge CLK_I);
    end
    RREADY_I <= 1'b0;
  endtask : rd
  // Timer is stopped before count and reload are touched
  task automatic setup(input logic [7:0] c, input logic f, input logic [15:0] rl);
    wr(ADDR_CTRL, 32'h0);
    wr(ADDR_RELOAD, {16'h0, rl});
    wr(ADDR_COUNT, {16'h0, rl});
    wr(ADDR_CFG, {31'h0, f});
    wr(ADDR_CTRL, {24'h0, c});
    repeat (40) @(posedge CLK_I);
    @(posedge CLK_I) clear <= 1'b1;
    @(posedge CLK_I) clear <= 1'b0;
  endtask : setup
  initial begin
    repeat (20000) @(posedge CLK_I);
    mismatches++;
    print_verdict();
  end
  initial begin
    {AWVALID_I, WVALID_I, BREADY_I, ARVALID_I, RREADY_I, clear} = 6'h00;
    {AWADDR_I, ARADDR_I, WDATA_I} = 42'h0;
    {EXT_COUNT_PIN_I, TRIGGER_PIN_I, RST_I} = 3'h7;
    repeat (5) @(posedge CLK_I);
    RST_I <= 1'b0;
    rd(ADDR_CTRL);
    chk("ctrl reset", {24'h0, CTRL_RESET}, d);
    rd(ADDR_MODE);
    chk("mode reset", {24'h0, MODE_RESET}, d);
    wr(ADDR_MODE, 32'hFF);
    rd(ADDR_MODE);
    chk("mode bits", 32'h3, d);
    wr(5'h14, 32'h1);
    chk("bad write", {30'h0, RESP_SLVERR}, {30'h0, r});
    rd(5'h14);
    chk("bad read", {30'h0, RESP_SLVERR}, {30'h0, r});
    wr(ADDR_MODE, 32'h0);
    $display("registers done");
    foreach (rows[i]) begin
      setup(rows[i].ctrl, rows[i].cfg, rows[i].rl);
      repeat (160) @(posedge CLK_I);
      @(negedge CLK_I);
      chk("tx ticks", {24'h0, rows[i].tx}, {24'h0, tx_cnt});
      chk("rx ticks", {24'h0, rows[i].rx}, {24'h0, rx_cnt});
    end
    $display("rate rows done");
    wr(ADDR_CTRL, 32'h3C);
    @(posedge CLK_I) TRIGGER_PIN_I <= 1'b0;
    repeat (4) @(posedge CLK_I);
    TRIGGER_PIN_I <= 1'b1;
    rd(ADDR_CTRL);
    @(negedge CLK_I);
    chk("flags", 32'h7C, d);
    chk("int on", 32'h1, {31'h0, TIMER_INT_O});
    wr(ADDR_MODE, 32'h1);
    @(negedge CLK_I);
    chk("int masked", 32'h0, {31'h0, TIMER_INT_O});
    wr(ADDR_MODE, 32'h0);
    $display("trigger done");
    setup(8'h36, 1'b1, 16'hFFFF);
    repeat (32) begin
      EXT_COUNT_PIN_I <= 1'b0;
      repeat (4) @(posedge CLK_I);
      EXT_COUNT_PIN_I <= 1'b1;
      repeat (4) @(posedge CLK_I);
    end
    repeat (6) @(posedge CLK_I);
    @(negedge CLK_I);
    chk("pin ticks", 32'h2, {24'h0, tx_cnt});
    $display("pin count done");
    // Counter set-up value leaves the timer stopped until the run bit follows
    wr(ADDR_CTRL, 32'h02);
    wr(ADDR_COUNT, 32'h0);
    wr(ADDR_CTRL, 32'h06);
    repeat (3) begin
      EXT_COUNT_PIN_I <= 1'b0;
      repeat (4) @(posedge CLK_I);
      EXT_COUNT_PIN_I <= 1'b1;
      repeat (4) @(posedge CLK_I);
    end
    repeat (6) @(posedge CLK_I);
    rd(ADDR_COUNT);
    chk("counter edges", 32'h3, d);
    $display("counter set-up done");
    RST_I <= 1'b1;
    repeat (2) @(posedge CLK_I);
    RST_I <= 1'b0;
    rd(ADDR_CTRL);
    chk("ctrl rereset", {24'h0, CTRL_RESET}, d);
    $display("second reset done");
    print_verdict();
  end
endmodule : test_timer2_baud_rate_generator
